// [design/itd_pkg.sv]
// constants for the interrupt and timer control instruction decoder
package itd_pkg;
	localparam int OPW = 10;
	localparam logic [9:0] DISABLE_INTERRUPTS_OP = 10'h004;
	localparam logic [9:0] ENABLE_INTERRUPTS_OP = 10'h005;
	localparam logic [9:0] SKIP_ON_EXT_REQUEST_OP = 10'h038;
	localparam logic [9:0] SKIP_ON_PIN_LEVEL_OP = 10'h03A;
	localparam logic [9:0] READ_IRQ_ENABLE_ONE_OP = 10'h054;
	localparam logic [9:0] READ_IRQ_ENABLE_TWO_OP = 10'h055;
	localparam logic [9:0] READ_PIN_CONTROL_OP = 10'h253;
	localparam logic [9:0] WRITE_IRQ_ENABLE_ONE_OP = 10'h03F;
	localparam logic [9:0] WRITE_IRQ_ENABLE_TWO_OP = 10'h03E;
	localparam logic [9:0] WRITE_PIN_CONTROL_OP = 10'h217;
	localparam logic [9:0] READ_TIMER_CTRL_ONE_OP = 10'h24B;
	localparam logic [9:0] READ_TIMER_CTRL_TWO_OP = 10'h24C;
	localparam logic [9:0] READ_TIMER_CTRL_THREE_OP = 10'h24D;
	localparam logic [9:0] WRITE_TIMER_CTRL_ONE_OP = 10'h20E;
	localparam logic [9:0] WRITE_TIMER_CTRL_TWO_OP = 10'h20F;
	localparam logic [9:0] WRITE_TIMER_CTRL_THREE_OP = 10'h210;
	localparam logic [9:0] READ_COUNT_STORE_OP = 10'h24F;
	localparam logic [9:0] WRITE_COUNT_STORE_OP = 10'h212;
	localparam logic [9:0] RETURN_FROM_INTERRUPT_OP = 10'h046;
	localparam logic [9:0] RETURN_SKIP_OP = 10'h045;
	localparam int PIN_POLARITY_POS = 2;
	localparam int COUNT_STORE_W = 2;
	localparam logic [3:0] REG_RESET = 4'h0;
	localparam logic [1:0] COUNT_RESET = 2'h0;
	localparam logic [1:0] ACC_UPPER_ZERO = 2'h0;
	typedef enum logic [2:0] {
		ITD_SKIP_IDLE = 3'b001,
		ITD_SKIP_ARMED = 3'b010,
		ITD_SKIP_HELD = 3'b100
	} itd_skip_t;
endpackage

// [design/itd_ctx_if.sv]
// context carried between the decoder and its interrupt context store
`timescale 1ns/1ps
`default_nettype none
interface itd_ctx_if #(parameter int DP_W = 8);
	logic save;
	logic restore;
	logic [DP_W-1:0] dp;
	logic cy;
	logic skip;
	logic nop;
	logic [3:0] a;
	logic [3:0] b;
	logic [DP_W-1:0] saved_dp;
	logic saved_cy;
	logic saved_skip;
	logic saved_nop;
	logic [3:0] saved_a;
	logic [3:0] saved_b;
	modport core (output save, restore, dp, cy, skip, nop, a, b,
		input saved_dp, saved_cy, saved_skip, saved_nop, saved_a, saved_b);
	modport store (input save, restore, dp, cy, skip, nop, a, b,
		output saved_dp, saved_cy, saved_skip, saved_nop, saved_a, saved_b);
endinterface
`default_nettype wire

// [design/itd_sync.sv]
// two-stage synchroniser for the external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module itd_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);
	logic stage_one;

	always_ff @(posedge clk) begin
		if (reset) begin
			stage_one <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage_one <= din;
			dout <= stage_one;
		end
	end
endmodule
`default_nettype wire

// [design/itd_ctx_store.sv]
// one-level context store filled on interrupt accept
`timescale 1ns/1ps
`default_nettype none
module itd_ctx_store #(parameter int DP_W = 8) (
	input wire logic clk,
	input wire logic reset,
	itd_ctx_if.store ctx
);
	always_ff @(posedge clk) begin
		if (reset) begin
			ctx.saved_dp <= '0;
			ctx.saved_cy <= 1'b0;
			ctx.saved_skip <= 1'b0;
			ctx.saved_nop <= 1'b0;
			ctx.saved_a <= 4'h0;
			ctx.saved_b <= 4'h0;
		end else if (ctx.save) begin
			ctx.saved_dp <= ctx.dp;
			ctx.saved_cy <= ctx.cy;
			ctx.saved_skip <= ctx.skip;
			ctx.saved_nop <= ctx.nop;
			ctx.saved_a <= ctx.a;
			ctx.saved_b <= ctx.b;
		end
	end
endmodule
`default_nettype wire

// [design/itd_decoder.sv]
// interrupt and timer control instruction decoder and its registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1 - opcode 0x004 clears the global interrupt enable flag in one cycle
// RQ2 - opcode 0x005 sets the global interrupt enable flag in one cycle
// RQ3 - opcode 0x038 skips the next instruction when the external request flag is 1
// RQ4 - a taken external request skip also clears that request flag
// RQ5 - opcode 0x03A skips when polarity bit is 1 and pin is high
// RQ6 - with polarity bit 0 opcode 0x03A skips only when pin is low
// RQ7 - opcodes 0x054, 0x055, 0x253 copy enable and pin control registers to accumulator
// RQ8 - opcodes 0x03F, 0x03E, 0x217 load accumulator into those control registers
// RQ9 - opcodes 0x24B, 0x24C, 0x24D copy timer control registers to accumulator
// RQ10 - opcodes 0x20E, 0x20F, 0x210 load accumulator into timer control registers
// RQ11 - opcode 0x24F copies count store register into accumulator bits 1 and 0
// RQ12 - that read forces accumulator bits 3 and 2 to zero
// RQ13 - opcode 0x212 writes accumulator bits 1 and 0 into count store register
// RQ14 - interrupt return restores pointer, carry, skip, nop status, A and B
// RQ15 - skipping subroutine return always suppresses the instruction after the call; the code loses the skip if irq_accept comes in the same cycle
// RQ16 - a skipped instruction is fetched but has no side effects at all
module itd_decoder
	import itd_pkg::*;
#(
	parameter int DP_W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [9:0] instr,
	input wire logic [3:0] acc_in,
	input wire logic [3:0] b_in,
	input wire logic [DP_W-1:0] dp_in,
	input wire logic cy_in,
	input wire logic nop_in,
	input wire logic int_pin,
	input wire logic ext_request_set,
	input wire logic irq_accept,
	output logic [3:0] acc_out,
	output logic acc_load,
	output logic instr_executed,
	output logic skip_status,
	output logic global_irq_enable_flag,
	output logic external_request_flag,
	output logic [3:0] irq_enable_reg_one,
	output logic [3:0] irq_enable_reg_two,
	output logic [3:0] pin_control_reg,
	output logic [3:0] timer_ctrl_reg_one,
	output logic [3:0] timer_ctrl_reg_two,
	output logic [3:0] timer_ctrl_reg_three,
	output logic [1:0] count_store_reg,
	output logic restore_valid,
	output logic [DP_W-1:0] restore_dp,
	output logic restore_cy,
	output logic restore_nop,
	output logic [3:0] restore_a,
	output logic [3:0] restore_b
);
	itd_ctx_if #(.DP_W(DP_W)) ctx ();
	itd_skip_t skip_state;
	itd_skip_t next_skip_state;
	logic pin_level;
	logic exec;
	logic skip_cond;
	logic is_rti;
	logic pin_match;
	logic [3:0] next_acc;
	logic next_acc_load;

	function automatic logic op_is(input logic ok, input logic [9:0] code,
		input logic [9:0] want);
		op_is = ok && (code == want);
	endfunction

	itd_sync pin_sync (
		.clk(clk),
		.reset(reset),
		.din(int_pin),
		.dout(pin_level)
	);

	itd_ctx_store #(.DP_W(DP_W)) ctx_store (
		.clk(clk),
		.reset(reset),
		.ctx(ctx)
	);

	// a word fetched under an armed skip is a no-operation
	assign exec = instr_valid && !skip_status; // RQ16
	assign is_rti = op_is(exec, instr, RETURN_FROM_INTERRUPT_OP);
	assign pin_match = pin_control_reg[PIN_POLARITY_POS] ? pin_level : !pin_level; // RQ5 RQ6

	always_comb begin
		skip_cond = 1'b0;
		if (op_is(exec, instr, SKIP_ON_EXT_REQUEST_OP)) begin
			skip_cond = external_request_flag; // RQ3
		end else if (op_is(exec, instr, SKIP_ON_PIN_LEVEL_OP)) begin
			skip_cond = pin_match; // RQ5 RQ6
		end else if (op_is(exec, instr, RETURN_SKIP_OP)) begin
			skip_cond = 1'b1; // RQ15
		end
	end

	// interrupt accept arrives between instructions; it parks the skip status
	assign ctx.save = irq_accept;
	assign ctx.restore = is_rti;
	assign ctx.dp = dp_in;
	assign ctx.cy = cy_in;
	assign ctx.skip = skip_status;
	assign ctx.nop = nop_in;
	assign ctx.a = acc_in;
	assign ctx.b = b_in;

	always_comb begin
		next_skip_state = skip_state;
		case (skip_state)
			ITD_SKIP_IDLE: begin
				if (skip_cond) begin
					next_skip_state = ITD_SKIP_ARMED;
				end
			end
			// held is a skip put back by an interrupt return
			ITD_SKIP_ARMED, ITD_SKIP_HELD: begin
				if (instr_valid) begin
					next_skip_state = ITD_SKIP_IDLE;
				end
			end
			default: begin
				next_skip_state = ITD_SKIP_IDLE;
			end
		endcase
		if (irq_accept) begin
			next_skip_state = ITD_SKIP_IDLE;
		end else if (is_rti) begin
			// the very next word is the one the interrupt cut off, so no delay here
			next_skip_state = ctx.saved_skip ? ITD_SKIP_HELD : ITD_SKIP_IDLE; // RQ14
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			skip_state <= ITD_SKIP_IDLE;
		end else begin
			skip_state <= next_skip_state;
		end
	end

	assign skip_status = (skip_state != ITD_SKIP_IDLE);
	assign instr_executed = exec;

	always_ff @(posedge clk) begin
		if (reset) begin
			global_irq_enable_flag <= 1'b0;
		end else if (op_is(exec, instr, DISABLE_INTERRUPTS_OP)) begin
			global_irq_enable_flag <= 1'b0; // RQ1
		end else if (op_is(exec, instr, ENABLE_INTERRUPTS_OP)) begin
			global_irq_enable_flag <= 1'b1; // RQ2
		end
	end

	// a new request in the clearing cycle survives
	always_ff @(posedge clk) begin
		if (reset) begin
			external_request_flag <= 1'b0;
		end else if (ext_request_set) begin
			external_request_flag <= 1'b1;
		end else if (op_is(exec, instr, SKIP_ON_EXT_REQUEST_OP) && external_request_flag) begin
			external_request_flag <= 1'b0; // RQ4
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_enable_reg_one <= REG_RESET;
			irq_enable_reg_two <= REG_RESET;
			pin_control_reg <= REG_RESET;
		end else begin
			if (op_is(exec, instr, WRITE_IRQ_ENABLE_ONE_OP)) begin
				irq_enable_reg_one <= acc_in; // RQ8
			end
			if (op_is(exec, instr, WRITE_IRQ_ENABLE_TWO_OP)) begin
				irq_enable_reg_two <= acc_in; // RQ8
			end
			if (op_is(exec, instr, WRITE_PIN_CONTROL_OP)) begin
				pin_control_reg <= acc_in; // RQ8
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			timer_ctrl_reg_one <= REG_RESET;
			timer_ctrl_reg_two <= REG_RESET;
			timer_ctrl_reg_three <= REG_RESET;
			count_store_reg <= COUNT_RESET;
		end else begin
			if (op_is(exec, instr, WRITE_TIMER_CTRL_ONE_OP)) begin
				timer_ctrl_reg_one <= acc_in; // RQ10
			end
			if (op_is(exec, instr, WRITE_TIMER_CTRL_TWO_OP)) begin
				timer_ctrl_reg_two <= acc_in; // RQ10
			end
			if (op_is(exec, instr, WRITE_TIMER_CTRL_THREE_OP)) begin
				timer_ctrl_reg_three <= acc_in; // RQ10
			end
			if (op_is(exec, instr, WRITE_COUNT_STORE_OP)) begin
				count_store_reg <= acc_in[COUNT_STORE_W-1:0]; // RQ13
			end
		end
	end

	always_comb begin
		next_acc = acc_out;
		next_acc_load = 1'b1;
		if (op_is(exec, instr, READ_IRQ_ENABLE_ONE_OP)) begin
			next_acc = irq_enable_reg_one; // RQ7
		end else if (op_is(exec, instr, READ_IRQ_ENABLE_TWO_OP)) begin
			next_acc = irq_enable_reg_two; // RQ7
		end else if (op_is(exec, instr, READ_PIN_CONTROL_OP)) begin
			next_acc = pin_control_reg; // RQ7
		end else if (op_is(exec, instr, READ_TIMER_CTRL_ONE_OP)) begin
			next_acc = timer_ctrl_reg_one; // RQ9
		end else if (op_is(exec, instr, READ_TIMER_CTRL_TWO_OP)) begin
			next_acc = timer_ctrl_reg_two; // RQ9
		end else if (op_is(exec, instr, READ_TIMER_CTRL_THREE_OP)) begin
			next_acc = timer_ctrl_reg_three; // RQ9
		end else if (op_is(exec, instr, READ_COUNT_STORE_OP)) begin
			next_acc = {ACC_UPPER_ZERO, count_store_reg}; // RQ11 RQ12
		end else begin
			next_acc_load = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			acc_out <= 4'h0;
			acc_load <= 1'b0;
		end else begin
			acc_out <= next_acc;
			acc_load <= next_acc_load;
		end
	end

	// restore values come from the store, pulse marks the cycle to take them
	always_ff @(posedge clk) begin
		if (reset) begin
			restore_valid <= 1'b0;
		end else begin
			restore_valid <= ctx.restore; // RQ14
		end
	end

	assign restore_dp = ctx.saved_dp;
	assign restore_cy = ctx.saved_cy;
	assign restore_nop = ctx.saved_nop;
	assign restore_a = ctx.saved_a;
	assign restore_b = ctx.saved_b;

	sequence skip_armed_s;
		skip_status;
	endsequence

	sequence next_word_s;
		instr_valid && !instr_executed;
	endsequence

	di_clear_a: assert property (@(posedge clk) disable iff (reset) // RQ1
		op_is(exec, instr, DISABLE_INTERRUPTS_OP) |=> !global_irq_enable_flag)
		else $error("interrupt disable did not clear the enable flag");

	ei_set_a: assert property (@(posedge clk) disable iff (reset) // RQ2
		op_is(exec, instr, ENABLE_INTERRUPTS_OP) |=> global_irq_enable_flag)
		else $error("interrupt enable did not set the enable flag");

	ext_skip_a: assert property (@(posedge clk) disable iff (reset) // RQ3
		op_is(exec, instr, SKIP_ON_EXT_REQUEST_OP) && !irq_accept |=>
		(skip_status == $past(external_request_flag)))
		else $error("request test skip does not follow the flag");

	ext_clear_a: assert property (@(posedge clk) disable iff (reset) // RQ4
		op_is(exec, instr, SKIP_ON_EXT_REQUEST_OP) && external_request_flag
		&& !ext_request_set |=> !external_request_flag)
		else $error("request flag not cleared after taken skip");

	pin_high_a: assert property (@(posedge clk) disable iff (reset) // RQ5
		op_is(exec, instr, SKIP_ON_PIN_LEVEL_OP) && !irq_accept
		&& pin_control_reg[PIN_POLARITY_POS] |=> skip_status == $past(pin_level))
		else $error("high level test skip wrong");

	pin_low_a: assert property (@(posedge clk) disable iff (reset) // RQ6
		op_is(exec, instr, SKIP_ON_PIN_LEVEL_OP) && !irq_accept
		&& !pin_control_reg[PIN_POLARITY_POS] |=> skip_status == !$past(pin_level))
		else $error("low level test skip wrong");

	reg_read_a: assert property (@(posedge clk) disable iff (reset) // RQ7
		op_is(exec, instr, READ_PIN_CONTROL_OP) |=> acc_load && acc_out == $past(pin_control_reg))
		else $error("pin control read wrong");

	reg_write_a: assert property (@(posedge clk) disable iff (reset) // RQ8
		op_is(exec, instr, WRITE_IRQ_ENABLE_TWO_OP) |=> irq_enable_reg_two == $past(acc_in))
		else $error("enable register two write wrong");

	timer_read_a: assert property (@(posedge clk) disable iff (reset) // RQ9
		op_is(exec, instr, READ_TIMER_CTRL_THREE_OP) |=> acc_out == $past(timer_ctrl_reg_three))
		else $error("timer control three read wrong");

	timer_write_a: assert property (@(posedge clk) disable iff (reset) // RQ10
		op_is(exec, instr, WRITE_TIMER_CTRL_ONE_OP) |=> timer_ctrl_reg_one == $past(acc_in))
		else $error("timer control one write wrong");

	count_read_a: assert property (@(posedge clk) disable iff (reset) // RQ11
		op_is(exec, instr, READ_COUNT_STORE_OP) |=> acc_out[1:0] == $past(count_store_reg))
		else $error("count store read wrong");

	count_upper_a: assert property (@(posedge clk) disable iff (reset) // RQ12
		op_is(exec, instr, READ_COUNT_STORE_OP) |=> acc_out[3:2] == 2'h0)
		else $error("count store read left upper bits set");

	count_write_a: assert property (@(posedge clk) disable iff (reset) // RQ13
		op_is(exec, instr, WRITE_COUNT_STORE_OP) |=> count_store_reg == $past(acc_in[1:0]))
		else $error("count store write wrong");

	rti_restore_a: assert property (@(posedge clk) disable iff (reset) // RQ14
		is_rti && !irq_accept |=> restore_valid && restore_a == $past(ctx.saved_a)
		&& skip_status == $past(ctx.saved_skip))
		else $error("interrupt return did not restore context");

	rts_skip_a: assert property (@(posedge clk) disable iff (reset) // RQ15
		op_is(exec, instr, RETURN_SKIP_OP) && !irq_accept |=> skip_armed_s)
		else $error("skipping return did not arm a skip");

	skip_nop_a: assert property (@(posedge clk) disable iff (reset) // RQ16
		skip_armed_s ##0 next_word_s |=> !acc_load && $stable(timer_ctrl_reg_one)
		&& $stable(global_irq_enable_flag) && !restore_valid)
		else $error("skipped word had a side effect");
endmodule
`default_nettype wire

// [tb/itd_decoder_tb.sv]
// self-checking bench for the interrupt and timer control decoder
`timescale 1ns/1ps
`default_nettype none
module itd_decoder_tb
	import itd_pkg::*;
;
	logic clk, reset, instr_valid, cy_in, nop_in, int_pin, ext_request_set, irq_accept;
	logic [9:0] instr;
	logic [3:0] acc_in, b_in, acc_out, restore_a, restore_b;
	logic [7:0] dp_in, restore_dp;
	logic acc_load, instr_executed, skip_status, global_irq_enable_flag;
	logic external_request_flag, restore_valid, restore_cy, restore_nop;
	logic [3:0] irq_enable_reg_one, irq_enable_reg_two, pin_control_reg;
	logic [3:0] timer_ctrl_reg_one, timer_ctrl_reg_two, timer_ctrl_reg_three;
	logic [1:0] count_store_reg;
	logic [3:0] regv [6];
	int err_count = 0;
	int checked = 0;
	localparam logic [9:0] WR_OPS [6] = '{WRITE_IRQ_ENABLE_ONE_OP, WRITE_IRQ_ENABLE_TWO_OP,
		WRITE_PIN_CONTROL_OP, WRITE_TIMER_CTRL_ONE_OP, WRITE_TIMER_CTRL_TWO_OP,
		WRITE_TIMER_CTRL_THREE_OP};
	localparam logic [9:0] RD_OPS [6] = '{READ_IRQ_ENABLE_ONE_OP, READ_IRQ_ENABLE_TWO_OP,
		READ_PIN_CONTROL_OP, READ_TIMER_CTRL_ONE_OP, READ_TIMER_CTRL_TWO_OP,
		READ_TIMER_CTRL_THREE_OP};
	// distinct patterns so a swapped register select shows up
	localparam logic [3:0] VALS [6] = '{4'hA, 4'h5, 4'h9, 4'hC, 4'h6, 4'h3};

	assign regv[0] = irq_enable_reg_one;
	assign regv[1] = irq_enable_reg_two;
	assign regv[2] = pin_control_reg;
	assign regv[3] = timer_ctrl_reg_one;
	assign regv[4] = timer_ctrl_reg_two;
	assign regv[5] = timer_ctrl_reg_three;

	itd_decoder #(.DP_W(8)) uut (.clk(clk), .reset(reset), .instr_valid(instr_valid),
		.instr(instr), .acc_in(acc_in), .b_in(b_in), .dp_in(dp_in), .cy_in(cy_in),
		.nop_in(nop_in), .int_pin(int_pin), .ext_request_set(ext_request_set),
		.irq_accept(irq_accept), .acc_out(acc_out), .acc_load(acc_load),
		.instr_executed(instr_executed), .skip_status(skip_status),
		.global_irq_enable_flag(global_irq_enable_flag),
		.external_request_flag(external_request_flag),
		.irq_enable_reg_one(irq_enable_reg_one), .irq_enable_reg_two(irq_enable_reg_two),
		.pin_control_reg(pin_control_reg), .timer_ctrl_reg_one(timer_ctrl_reg_one),
		.timer_ctrl_reg_two(timer_ctrl_reg_two), .timer_ctrl_reg_three(timer_ctrl_reg_three),
		.count_store_reg(count_store_reg), .restore_valid(restore_valid),
		.restore_dp(restore_dp), .restore_cy(restore_cy), .restore_nop(restore_nop),
		.restore_a(restore_a), .restore_b(restore_b));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// presents one word at a falling edge, returns at the next one
	task automatic issue(input logic [9:0] op, input logic [3:0] a);
		instr_valid = 1'b1;
		instr = op;
		acc_in = a;
		#1;
		chk(instr_executed, 1'b1);
		@(negedge clk);
	endtask

	// word expected to be swallowed by a pending skip
	task automatic skipped(input logic [9:0] op, input logic [3:0] a);
		instr_valid = 1'b1;
		instr = op;
		acc_in = a;
		#1;
		chk(instr_executed, 1'b0);
		@(negedge clk);
	endtask

	task automatic idle(input int n);
		instr_valid = 1'b0;
		repeat (n) @(negedge clk);
	endtask

	task automatic raise_request();
		ext_request_set = 1'b1;
		idle(1);
		ext_request_set = 1'b0;
	endtask

	// hang guard: no scenario needs anywhere near this many cycles
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		conclude();
	end

	initial begin
		reset = 1'b1;
		instr_valid = 1'b0;
		instr = 10'h000;
		acc_in = 4'h0;
		b_in = 4'h0;
		dp_in = 8'h00;
		cy_in = 1'b0;
		nop_in = 1'b0;
		int_pin = 1'b0;
		ext_request_set = 1'b0;
		irq_accept = 1'b0;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		chk({global_irq_enable_flag, external_request_flag, skip_status, acc_load,
			restore_valid, count_store_reg}, 24'h0);
		chk({irq_enable_reg_one, irq_enable_reg_two, pin_control_reg, timer_ctrl_reg_one,
			timer_ctrl_reg_two, timer_ctrl_reg_three}, 24'h0);
		// back to back set and clear of the global enable
		issue(ENABLE_INTERRUPTS_OP, 4'h0);
		chk(global_irq_enable_flag, 1'b1);
		issue(DISABLE_INTERRUPTS_OP, 4'h0);
		chk(global_irq_enable_flag, 1'b0);
		for (int i = 0; i < 6; i++) begin
			issue(WR_OPS[i], VALS[i]);
			chk({acc_load, regv[i]}, {1'b0, VALS[i]});
			issue(RD_OPS[i], 4'h0);
			chk({acc_load, acc_out}, {1'b1, VALS[i]});
		end
		issue(WRITE_COUNT_STORE_OP, 4'hE);
		chk(count_store_reg, 2'h2);
		issue(READ_COUNT_STORE_OP, 4'hF);
		chk({acc_load, acc_out}, {1'b1, 4'h2});
		issue(WRITE_COUNT_STORE_OP, 4'h7);
		issue(READ_COUNT_STORE_OP, 4'h0);
		chk(acc_out, 4'h3);
		// taken request skip swallows an enable
		raise_request();
		chk(external_request_flag, 1'b1);
		issue(SKIP_ON_EXT_REQUEST_OP, 4'h0);
		chk({skip_status, external_request_flag}, 2'h2);
		skipped(ENABLE_INTERRUPTS_OP, 4'h0);
		chk({skip_status, global_irq_enable_flag}, 2'h0);
		issue(SKIP_ON_EXT_REQUEST_OP, 4'h0);
		chk(skip_status, 1'b0);
		issue(ENABLE_INTERRUPTS_OP, 4'h0);
		chk(global_irq_enable_flag, 1'b1);
		// all four polarity and pin level pairs
		for (int k = 0; k < 4; k++) begin
			issue(WRITE_PIN_CONTROL_OP, {1'b0, k[1], 2'h0});
			int_pin = k[0];
			idle(3);
			issue(SKIP_ON_PIN_LEVEL_OP, 4'h0);
			chk(skip_status, k[1] == k[0]);
			if (k[1] == k[0]) begin
				skipped(WRITE_IRQ_ENABLE_ONE_OP, 4'hF);
				chk(irq_enable_reg_one, 4'hA);
			end else begin
				issue(10'h000, 4'h0);
			end
		end
		// interrupt taken while a skip is pending, then returned from
		raise_request();
		issue(SKIP_ON_EXT_REQUEST_OP, 4'h0);
		instr_valid = 1'b0;
		irq_accept = 1'b1;
		dp_in = 8'h5A;
		cy_in = 1'b1;
		nop_in = 1'b1;
		acc_in = 4'h6;
		b_in = 4'h9;
		@(negedge clk);
		irq_accept = 1'b0;
		dp_in = 8'h00;
		cy_in = 1'b0;
		nop_in = 1'b0;
		b_in = 4'h0;
		chk(skip_status, 1'b0);
		issue(WRITE_COUNT_STORE_OP, 4'h1);
		chk(count_store_reg, 2'h1);
		issue(RETURN_FROM_INTERRUPT_OP, 4'h0);
		chk({restore_valid, skip_status, restore_dp, restore_cy, restore_nop, restore_a,
			restore_b}, {2'h3, 8'h5A, 1'b1, 1'b1, 4'h6, 4'h9});
		// the word right after the return must be the one dropped
		skipped(WRITE_COUNT_STORE_OP, 4'h3);
		chk({restore_valid, skip_status}, 2'h0);
		chk(count_store_reg, 2'h1);
		// skipping return drops the next word when no interrupt is accepted with it
		issue(RETURN_SKIP_OP, 4'h0);
		chk(skip_status, 1'b1);
		skipped(WRITE_TIMER_CTRL_ONE_OP, 4'h0);
		chk({skip_status, timer_ctrl_reg_one}, {1'b0, 4'hC});
		// second reset in mid-run
		reset = 1'b1;
		idle(2);
		reset = 1'b0;
		chk({global_irq_enable_flag, timer_ctrl_reg_three, count_store_reg}, 24'h0);
		idle(2);
		conclude();
	end
endmodule
`default_nettype wire
